// [hw/rssi_agc_control.sv]
// signal-level readout, gain loop, fine calibration and receive data routing
// Notes on behaviour
// - above upper limit reduce gain, below lower raise
// - limits reset to 30 and 70
// - gain loop enabled from reset
// - level is 7-bit code, 80 levels
// - offset clock is system clock over 4/8/16/32
// - one update period between gain evaluations
// - at most five gain settings stepped
// - loop off when fixed mode written
// - fine calibration runs ten iterations
// - iteration lasts dwell count of sequencer ticks
// - readback holds level on top, gain codes
// - gain codes high 10, medium 01, low 00
// - correlator for 2/3/4 levels, linear when selected at 2 levels
// - threshold slicing, trellis option for 3 levels
// - retimed data and bit clock on pins
// - envelope is linear-mode slicer threshold and frequency estimate
// - gains from loop when enabled, else fields
`timescale 1ns/1ps
`default_nettype none
`include "rssi_agc_params.svh"
module rssi_agc_control (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [7:0] raw_level,
  input wire logic signed [7:0] corr_level,
  input wire logic signed [7:0] lin_level,
  input wire logic signed [7:0] envelope_level,
  input wire logic trellis_bit,
  input wire logic cdr_strobe,
  output logic [1:0] front_amp_gain_code,
  output logic [1:0] filter_gain_code,
  output logic front_amp_operating_select,
  output logic front_amp_detach,
  output logic tone_adjust,
  output logic offset_corr_clock,
  output logic linear_demod_enable,
  output logic radio_data_pin,
  output logic radio_bit_clock_pin
);

  ////////////////////////////////////////////////////////////////////////
  // register state
  rssi_agc_pkg::control_type ctl_q;
  logic [6:0] lower_q;
  logic [6:0] upper_q;
  logic [7:0] seq_div_q;
  logic [5:0] gain_div_q;
  logic [15:0] dwell_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic cal_go_q;
  logic limits_touched_q;
  logic [`GAIN_IDX_W-1:0] gain_idx_q;
  rssi_agc_pkg::cal_state_type cal_q;
  logic [`CAL_ITER_W-1:0] iter_q;
  logic [15:0] dwell_cnt_q;
  logic [6:0] cal_level_q;
  logic signed [7:0] freq_est_q;
  logic sym_phase_q;

  // gain step index to code pair
  function automatic rssi_agc_pkg::gain_pair_type gain_of(input logic [`GAIN_IDX_W-1:0] idx);
    rssi_agc_pkg::gain_pair_type g;
    case (idx)
      3'h0: g = '{front: `GAIN_HIGH, filter: `GAIN_HIGH};
      3'h1: g = '{front: `GAIN_MED, filter: `GAIN_HIGH};
      3'h2: g = '{front: `GAIN_MED, filter: `GAIN_MED};
      3'h3: g = '{front: `GAIN_MED, filter: `GAIN_LOW};
      default: g = '{front: `GAIN_LOW, filter: `GAIN_LOW};
    endcase
    return g;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // level code and pacing ticks
  logic [`LEVEL_W-1:0] level;
  logic seq_tick;
  logic gain_tick;
  logic ofs_tick;
  logic [5:0] ofs_half;

  level_quantizer u_quant (
    .sys_clk(sys_clk),
    .rst(rst),
    .raw_level(raw_level),
    .level_code(level)
  );

  tick_divider #(.W(8)) u_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .en(1'b1),
    .div(seq_div_q),
    .tick(seq_tick)
  );

  // gain update rate is sequencer tick over tick divider
  tick_divider #(.W(6)) u_gain (
    .sys_clk(sys_clk),
    .rst(rst),
    .en(seq_tick),
    .div(gain_div_q),
    .tick(gain_tick)
  );

  // half period of 2, 4, 8 or 16 system cycles
  assign ofs_half = `OFS_HALF_BASE << ctl_q.ofs_div_sel;

  tick_divider #(.W(6)) u_ofs (
    .sys_clk(sys_clk),
    .rst(rst),
    .en(1'b1),
    .div(ofs_half),
    .tick(ofs_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic addr_phase;
  logic wr_now;
  logic [31:0] level_word;
  logic [31:0] rd_mux;
  logic [31:0] ctl_word;
  rssi_agc_pkg::gain_pair_type active_gain;

  assign addr_phase = hsel && hready && htrans[1];
  assign wr_now = wr_pend_q;
  assign ctl_word = {9'h0, ctl_q.slice_thr, 1'b0, ctl_q.fsk_levels, ctl_q.trellis,
                     ctl_q.freq_loop, ctl_q.linear_sel, ctl_q.ofs_div_sel, 1'b0,
                     ctl_q.fa_mode, ctl_q.fg_field, ctl_q.fa_field, 1'b0, ctl_q.loop_en};
  // level on top of eleven bits, then front and filter codes
  assign level_word = {9'h0, cal_level_q, (cal_q != rssi_agc_pkg::CAL_IDLE), iter_q,
                       level, front_amp_gain_code, filter_gain_code};
  assign rd_mux = (haddr[7:0] == `OFS_CONTROL) ? ctl_word :
                  (haddr[7:0] == `OFS_LIMITS) ? {17'h0, upper_q, 1'b0, lower_q} :
                  (haddr[7:0] == `OFS_TIMING) ? {dwell_q, 2'h0, gain_div_q, seq_div_q} :
                  (haddr[7:0] == `OFS_LEVEL_READ) ? level_word :
                  (haddr[7:0] == `OFS_FREQ_READ) ? {{24{freq_est_q[7]}}, freq_est_q} :
                  32'h0;

  // zero wait state slave, read data loaded in address phase
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase)
        wr_addr_q <= haddr[7:0];
      if (addr_phase && !hwrite)
        hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes in data phase
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_q <= '{loop_en: 1'b1, ofs_div_sel: `OFS_DIV_SEL_RST, default: '0};
      lower_q <= `LIMIT_LOWER_RST;
      upper_q <= `LIMIT_UPPER_RST;
      seq_div_q <= `SEQ_DIV_RST;
      gain_div_q <= `GAIN_DIV_RST;
      dwell_q <= 16'(`DWELL_RST);
      cal_go_q <= 1'b0;
      limits_touched_q <= 1'b0;
    end
    else
    begin
      cal_go_q <= wr_now && (wr_addr_q == `OFS_CONTROL) && hwdata[`CTL_CAL_START];
      if (wr_now && (wr_addr_q == `OFS_CONTROL))
      begin
        // clearing the enable selects a fixed receiver mode
        ctl_q.loop_en <= hwdata[`CTL_LOOP_EN];
        ctl_q.fa_field <= hwdata[`CTL_FA_GAIN_LSB +: 2];
        ctl_q.fg_field <= hwdata[`CTL_FG_GAIN_LSB +: 2];
        ctl_q.fa_mode <= hwdata[`CTL_FA_MODE];
        ctl_q.ofs_div_sel <= hwdata[`CTL_OFS_DIV_LSB +: 2];
        ctl_q.linear_sel <= hwdata[`CTL_LINEAR_SEL];
        ctl_q.freq_loop <= hwdata[`CTL_FREQ_LOOP];
        ctl_q.trellis <= hwdata[`CTL_TRELLIS];
        ctl_q.fsk_levels <= hwdata[`CTL_FSK_LSB +: 2];
        ctl_q.slice_thr <= hwdata[`CTL_SLICE_LSB +: 7];
      end
      if (wr_now && (wr_addr_q == `OFS_LIMITS))
      begin
        lower_q <= hwdata[`LIM_LOWER_LSB +: 7];
        upper_q <= hwdata[`LIM_UPPER_LSB +: 7];
        limits_touched_q <= 1'b1;
      end
      if (wr_now && (wr_addr_q == `OFS_TIMING))
      begin
        seq_div_q <= hwdata[`TIM_SEQ_LSB +: 8];
        gain_div_q <= hwdata[`TIM_GAIN_LSB +: 6];
        dwell_q <= hwdata[`TIM_DWELL_LSB +: 16];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gain loop: one decision per update tick
  logic loop_run;
  logic go_down;
  logic go_up;

  assign loop_run = ctl_q.loop_en && gain_tick && (cal_q == rssi_agc_pkg::CAL_IDLE);
  assign go_down = (level > upper_q) && (gain_idx_q < `GAIN_IDX_MAX);
  assign go_up = (level < lower_q) && (gain_idx_q > `GAIN_IDX_MIN);
  assign active_gain = ctl_q.loop_en ? gain_of(gain_idx_q)
                                     : {ctl_q.fa_field, ctl_q.fg_field};

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      gain_idx_q <= `GAIN_IDX_MIN;
    else if (loop_run && go_down)
      gain_idx_q <= gain_idx_q + `GAIN_IDX_W'(1);
    else if (loop_run && go_up)
      gain_idx_q <= gain_idx_q - `GAIN_IDX_W'(1);
    // otherwise the setting holds
  end

  // registered gain outputs
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      front_amp_gain_code <= `GAIN_HIGH;
      filter_gain_code <= `GAIN_HIGH;
      front_amp_operating_select <= 1'b0;
    end
    else
    begin
      front_amp_gain_code <= active_gain.front;
      filter_gain_code <= active_gain.filter;
      front_amp_operating_select <= ctl_q.fa_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fine calibration: step the centre, dwell, measure, ten times
  logic dwell_done;

  assign dwell_done = seq_tick && (dwell_cnt_q + 16'h1 >= dwell_q);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cal_q <= rssi_agc_pkg::CAL_IDLE;
      iter_q <= '0;
      dwell_cnt_q <= 16'h0;
      cal_level_q <= 7'h0;
      tone_adjust <= 1'b0;
      front_amp_detach <= 1'b0;
    end
    else
    begin
      tone_adjust <= 1'b0;
      front_amp_detach <= (cal_q != rssi_agc_pkg::CAL_IDLE) || cal_go_q;
      case (cal_q)
        rssi_agc_pkg::CAL_IDLE:
          if (cal_go_q)
          begin
            iter_q <= '0;
            cal_q <= rssi_agc_pkg::CAL_STEP;
          end
        rssi_agc_pkg::CAL_STEP:
        begin
          tone_adjust <= 1'b1;
          dwell_cnt_q <= 16'h0;
          cal_q <= rssi_agc_pkg::CAL_DWELL;
        end
        rssi_agc_pkg::CAL_DWELL:
          if (dwell_done)
          begin
            cal_level_q <= level;
            if (iter_q == `CAL_ITER_LAST)
              cal_q <= rssi_agc_pkg::CAL_IDLE;
            else
            begin
              iter_q <= iter_q + `CAL_ITER_W'(1);
              cal_q <= rssi_agc_pkg::CAL_STEP;
            end
          end
          else if (seq_tick)
            dwell_cnt_q <= dwell_cnt_q + 16'h1;
        default: cal_q <= rssi_agc_pkg::CAL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // demodulator routing and slicing
  logic use_linear;
  logic signed [7:0] demod_in;
  logic signed [7:0] thr_pos;
  logic signed [7:0] two_ref;
  logic bit_two;
  logic bit_three;
  logic [1:0] sym_four;
  logic next_bit;

  assign use_linear = ctl_q.linear_sel && (ctl_q.fsk_levels == `FSK_TWO);
  assign demod_in = use_linear ? lin_level : corr_level;
  assign thr_pos = {1'b0, ctl_q.slice_thr};
  assign two_ref = use_linear ? envelope_level : 8'sh00;
  assign bit_two = demod_in > two_ref;
  assign bit_three = ctl_q.trellis ? trellis_bit
                                   : ((demod_in > thr_pos) || (demod_in < -thr_pos));
  assign sym_four = {demod_in > 8'sh00,
                     (demod_in > thr_pos) || (demod_in < -thr_pos)};
  assign next_bit = (ctl_q.fsk_levels == `FSK_THREE) ? bit_three :
                    (ctl_q.fsk_levels == `FSK_FOUR) ? sym_four[sym_phase_q] : bit_two;

  // retime onto the data pin at each recovered bit strobe
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      radio_data_pin <= 1'b0;
      radio_bit_clock_pin <= 1'b0;
      sym_phase_q <= 1'b1;
      linear_demod_enable <= 1'b0;
      freq_est_q <= 8'sh00;
      offset_corr_clock <= 1'b0;
    end
    else
    begin
      radio_bit_clock_pin <= cdr_strobe;
      if (cdr_strobe)
      begin
        radio_data_pin <= next_bit;
        sym_phase_q <= (ctl_q.fsk_levels == `FSK_FOUR) ? ~sym_phase_q : 1'b1;
      end
      linear_demod_enable <= ctl_q.freq_loop || use_linear;
      freq_est_q <= envelope_level;
      if (ofs_tick)
        offset_corr_clock <= ~offset_corr_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_reduce_above: assert property (loop_run && go_down |=> gain_idx_q == $past(gain_idx_q) + 3'h1)
    else $error("gain not reduced above upper limit");
  a_raise_below: assert property (loop_run && !go_down && go_up |=> gain_idx_q == $past(gain_idx_q) - 3'h1)
    else $error("gain not raised below lower limit");
  a_hold_between: assert property (level >= lower_q && level <= upper_q |=> $stable(gain_idx_q))
    else $error("gain moved between limits");
  a_limit_defaults: assert property (!limits_touched_q |-> lower_q == 7'h1E && upper_q == 7'h46)
    else $error("limit defaults wrong");
  a_level_range: assert property (level <= 7'h4F && gain_idx_q <= 3'h4)
    else $error("level or gain index out of range");
  a_gain_pacing: assert property ($changed(gain_idx_q) |-> $past(gain_tick))
    else $error("gain changed off the update tick");
  a_fixed_gains: assert property (!ctl_q.loop_en |=> front_amp_gain_code == $past(ctl_q.fa_field))
    else $error("fixed gain not taken from field");
  a_code_medium: assert property (ctl_q.loop_en && gain_idx_q == 3'h2 |=> front_amp_gain_code == 2'h1 && filter_gain_code == 2'h1)
    else $error("medium gain code wrong");
  a_cal_ten: assert property ($rose(cal_q == rssi_agc_pkg::CAL_IDLE) |-> $past(iter_q) == 4'h9)
    else $error("calibration ended early");
  a_bit_clock: assert property (cdr_strobe |=> radio_bit_clock_pin ##1 !radio_bit_clock_pin || $past(cdr_strobe))
    else $error("bit clock not following strobe");

  c_gain_down: cover property (loop_run && go_down);
  c_cal_done: cover property ($rose(cal_q == rssi_agc_pkg::CAL_IDLE));
  c_four_level: cover property (cdr_strobe && ctl_q.fsk_levels == 2'h2);

endmodule
`default_nettype wire

// [hw/rssi_agc_params.svh]
// constants for the signal-level and gain loop control block
`ifndef RSSI_AGC_PARAMS_SVH
`define RSSI_AGC_PARAMS_SVH

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_LIMITS 8'h04
`define OFS_TIMING 8'h08
`define OFS_LEVEL_READ 8'h0C
`define OFS_FREQ_READ 8'h10

// level code: 80 levels in 7 bits
`define LEVEL_W 7
`define LEVEL_MAX 7'h4F
`define LIMIT_LOWER_RST 7'h1E
`define LIMIT_UPPER_RST 7'h46

// five combined gain steps, index 0 is highest gain
`define GAIN_IDX_W 3
`define GAIN_IDX_MIN 3'h0
`define GAIN_IDX_MAX 3'h4

// two-bit gain codes
`define GAIN_HIGH 2'h2
`define GAIN_MED 2'h1
`define GAIN_LOW 2'h0

// pacing: 20 MHz system clock, 100 kHz sequencer tick
`define SYS_CLK_KHZ 20000
`define SEQ_CLK_KHZ 100
`define SEQ_DIV_RST 8'hC8
`define GAIN_DIV_RST 6'h0A
`define TONE_DWELL_US 500
`define DWELL_RST ((`TONE_DWELL_US * `SEQ_CLK_KHZ) / 1000)

// offset clock divider select, 2 means divide by 16
`define OFS_DIV_SEL_RST 2'h2
`define OFS_HALF_BASE 6'h02

// fine calibration iterations
`define CAL_ITER_W 4
`define CAL_ITER_LAST 4'h9

// control register fields
`define CTL_LOOP_EN 0
`define CTL_CAL_START 1
`define CTL_FA_GAIN_LSB 2
`define CTL_FG_GAIN_LSB 4
`define CTL_FA_MODE 6
`define CTL_OFS_DIV_LSB 8
`define CTL_LINEAR_SEL 10
`define CTL_FREQ_LOOP 11
`define CTL_TRELLIS 12
`define CTL_FSK_LSB 13
`define CTL_SLICE_LSB 16

// limit and timing register fields
`define LIM_LOWER_LSB 0
`define LIM_UPPER_LSB 8
`define TIM_SEQ_LSB 0
`define TIM_GAIN_LSB 8
`define TIM_DWELL_LSB 16

// fsk level selection
`define FSK_TWO 2'h0
`define FSK_THREE 2'h1
`define FSK_FOUR 2'h2

`endif

// [hw/rssi_agc_pkg.sv]
// types shared by the signal-level and gain loop control block
package rssi_agc_pkg;

  // front amplifier and filter gain codes travel together
  typedef struct packed {
    logic [1:0] front;
    logic [1:0] filter;
  } gain_pair_type;

  // software control fields
  typedef struct packed {
    logic loop_en;
    logic [1:0] fa_field;
    logic [1:0] fg_field;
    logic fa_mode;
    logic [1:0] ofs_div_sel;
    logic linear_sel;
    logic freq_loop;
    logic trellis;
    logic [1:0] fsk_levels;
    logic [6:0] slice_thr;
  } control_type;

  // fine calibration sequencer
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_STEP = 3'b010,
    CAL_DWELL = 3'b100
  } cal_state_type;

endpackage

// [hw/tick_divider.sv]
// enable-pulse divider: one tick every div enabled cycles
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [W-1:0] div,
  output logic tick
);

  logic [W-1:0] cnt_q;
  logic wrap;

  // a divider of zero behaves as one
  assign wrap = (div == '0) || (cnt_q >= div - W'(1));

  // count enabled cycles, pulse on wrap
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= en && wrap;
      if (en)
        cnt_q <= wrap ? '0 : cnt_q + W'(1);
    end
  end

endmodule
`default_nettype wire

// [hw/level_quantizer.sv]
// flash quantizer of the log-amp level into an 80-step code
`timescale 1ns/1ps
`default_nettype none
`include "rssi_agc_params.svh"
module level_quantizer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] raw_level,
  output logic [`LEVEL_W-1:0] level_code
);

  logic over;

  // anything above the top step saturates
  assign over = raw_level > {1'b0, `LEVEL_MAX};

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      level_code <= '0;
    else
      level_code <= over ? `LEVEL_MAX : raw_level[`LEVEL_W-1:0];
  end

endmodule
`default_nettype wire

// [tb/front_end_model.sv]
// stand-in for the analog gain stages ahead of the log amp
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  input wire logic sys_clk,
  input wire logic [1:0] front_amp_gain_code,
  input wire logic [1:0] filter_gain_code,
  input wire logic [15:0] pw,
  output logic [7:0] raw_level
);
  int corr;
  int lv;
  ////////////////////////////////////////
  // lower gain pulls the level down by the gain mode correction
  always_comb
  begin
    case ({front_amp_gain_code, filter_gain_code})
      4'hA: corr = 0;
      4'h6: corr = 24;
      4'h5: corr = 38;
      4'h4: corr = 58;
      default: corr = 86;
    endcase
    lv = int'(pw) - corr;
  end
  // level settles one cycle after a gain change
  always_ff @(posedge sys_clk)
  begin
    raw_level <= (lv < 0) ? 8'h00 : (lv > 255) ? 8'hFF : 8'(lv);
  end
endmodule
`default_nettype wire

// [tb/test_rssi_agc_control.sv]
// self-checking bench for the signal-level and gain loop block
`timescale 1ns/1ps
`default_nettype none
`include "rssi_agc_params.svh"
module test_rssi_agc_control;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, fa_sel, detach, tone, ofs_clk, lin_en, rx_data, rx_clk;
  logic [7:0] raw_level;
  logic signed [7:0] corr_level = 8'sh00, lin_level = 8'sh00, env_level = 8'sh00;
  logic trellis_bit = 1'b0;
  logic cdr_strobe = 1'b0;
  logic [1:0] fa_code, fg_code;
  logic [3:0] prev;
  logic [15:0] pw = 16'h0;
  logic pace_on = 1'b0;
  int miscompares = 0;
  int checked = 0;
  int fc[5] = '{2, 1, 1, 1, 0};
  int gc[5] = '{2, 2, 1, 0, 0};
  int cr[5] = '{0, 24, 38, 58, 86};
  int plist[5] = '{20, 200, 100, 150, 60};
  int ctl[5] = '{32'h201, 32'h601, 32'h142201, 32'h143A01, 32'h144201};
  int idx = 0;
  int cyc = 0;
  int last_chg = -1000;
  int n, pulses, gap, last, dh;

  always #25 sys_clk = ~sys_clk;

  rssi_agc_control rssi_agc_control_inst (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .raw_level(raw_level),
    .corr_level(corr_level), .lin_level(lin_level), .envelope_level(env_level),
    .trellis_bit(trellis_bit), .cdr_strobe(cdr_strobe), .front_amp_gain_code(fa_code),
    .filter_gain_code(fg_code), .front_amp_operating_select(fa_sel),
    .front_amp_detach(detach), .tone_adjust(tone), .offset_corr_clock(ofs_clk),
    .linear_demod_enable(lin_en), .radio_data_pin(rx_data), .radio_bit_clock_pin(rx_clk)
  );
  front_end_model front_end_model_inst (
    .sys_clk(sys_clk), .front_amp_gain_code(fa_code), .filter_gain_code(fg_code),
    .pw(pw), .raw_level(raw_level)
  );
  ////////////////////////////////////////
  // gain steps must stay one update period apart
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    prev <= {fa_code, fg_code};
    if (!rst && pace_on && prev !== {fa_code, fg_code})
    begin
      if (cyc - last_chg < 40)
        check("gain step spacing", 6, cyc - last_chg);
      last_chg <= cyc;
    end
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        check("hready wait", 1, 0);
        final_report();
      end
      @(posedge sys_clk);
    end
  endtask
  // one single word transfer, read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
    check("hresp", 0, hresp);
  endtask
  function automatic int level_of(input int p, input int i);
    int v;
    v = p - cr[i];
    if (v < 0)
      v = 0;
    if (v > 79)
      v = 79;
    return v;
  endfunction
  // apply a power, let the loop settle, compare with the stepping model
  task automatic settle(input int p);
    int lv;
    @(posedge sys_clk);
    pw <= 16'(p);
    repeat (80) @(posedge sys_clk);
    #1;
    repeat (6)
    begin
      lv = level_of(p, idx);
      if (lv > 70 && idx < 4)
        idx++;
      else if (lv < 30 && idx > 0)
        idx--;
    end
    lv = level_of(p, idx);
    check("front code", fc[idx], fa_code);
    check("filter code", gc[idx], fg_code);
    bus(0, `OFS_LEVEL_READ, 0, rd);
    check("level read", lv * 16 + fc[idx] * 4 + gc[idx], rd[10:0]);
  endtask
  // measure offset clock period between its second and third rise
  task automatic ofs_gap(output int g);
    int c;
    int r0;
    logic p;
    c = 0;
    g = 0;
    r0 = 0;
    p = 1'b1;
    for (int k = 0; k < 300; k++)
    begin
      @(posedge sys_clk);
      #1;
      if (ofs_clk === 1'b1 && p === 1'b0)
      begin
        c++;
        if (c == 3)
          g = k - r0;
        r0 = k;
      end
      p = ofs_clk;
    end
  endtask
  // one recovered bit with random demodulator samples
  task automatic rx_bit(input int m, input int j);
    int c;
    int e;
    int t;
    int exp;
    c = int'($urandom_range(200)) - 100;
    if (c == 0)
      c = 7;
    e = c - 9 + 18 * int'($urandom_range(1));
    t = int'($urandom_range(1));
    exp = (m == 0) ? (c > 0) : (m == 1) ? (c > e) : (m == 2) ? (c > 20 || c < -20) : t;
    // four levels: sign bit first, then outer flag, alternately
    if (m == 4)
      exp = (j % 2 == 0) ? (c > 0) : (c > 20 || c < -20);
    @(posedge sys_clk);
    corr_level <= 8'(c);
    lin_level <= 8'(c);
    env_level <= 8'(e);
    trellis_bit <= 1'(t);
    @(posedge sys_clk);
    cdr_strobe <= 1'b1;
    @(posedge sys_clk);
    cdr_strobe <= 1'b0;
    #1;
    check("bit clock", 1, rx_clk);
    check("rx data", exp, rx_data);
    check("linear enable", m % 2, lin_en);
    @(posedge sys_clk);
    #1;
    check("bit clock end", 0, rx_clk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    rd = $urandom(32'h81074230);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    check("reset codes", 32'hA, {fa_code, fg_code});
    bus(0, `OFS_CONTROL, 0, rd);
    check("control reset", 32'h201, rd);
    bus(0, `OFS_LIMITS, 0, rd);
    check("limits reset", 32'h461E, rd);
    bus(0, `OFS_TIMING, 0, rd);
    check("timing reset", 32'h320AC8, rd);
    bus(1, 8'h20, 32'hFFFFFFFF, rd);
    bus(0, 8'h20, 0, rd);
    check("unmapped read", 0, rd);
    $display("test reset values done");
    bus(1, `OFS_TIMING, 32'h00020302, rd);
    pace_on = 1'b1;
    foreach (plist[i]) settle(plist[i]);
    pace_on = 1'b0;
    $display("test gain loop done");
    for (int f = 0; f < 3; f++)
    begin
      bus(1, `OFS_CONTROL, 32'h240 | (f << 2) | ((2 - f) << 4), rd);
      pw <= 16'd200;
      repeat (20) @(posedge sys_clk);
      check("fixed front", f, fa_code);
      check("fixed filter", 2 - f, fg_code);
      check("amp mode", 1, fa_sel);
    end
    $display("test fixed mode done");
    for (int s = 0; s < 4; s++)
    begin
      bus(1, `OFS_CONTROL, 32'h1 | (s << 8), rd);
      ofs_gap(n);
      check("offset period", 4 << s, n);
      check("amp mode off", 0, fa_sel);
    end
    $display("test offset clock done");
    bus(1, `OFS_CONTROL, 32'h203, rd);
    pulses = 0;
    gap = 1000;
    last = 0;
    dh = 0;
    for (int k = 0; k < 3000; k++)
    begin
      @(posedge sys_clk);
      #1;
      dh += (detach === 1'b1);
      if (tone === 1'b1)
      begin
        if (pulses > 0 && k - last < gap)
          gap = k - last;
        pulses++;
        last = k;
      end
      if (detach !== 1'b1 && k > 2)
        break;
    end
    check("iterations", 10, pulses);
    check("dwell spacing", 1, gap >= 4);
    check("detach seen", 1, dh > 40);
    bus(0, `OFS_LEVEL_READ, 0, rd);
    check("cal busy clear", 0, rd[15]);
    $display("test calibration done");
    for (int m = 0; m < 5; m++)
    begin
      bus(1, `OFS_CONTROL, ctl[m], rd);
      for (int j = 0; j < 4; j++)
        rx_bit(m, j);
      bus(0, `OFS_FREQ_READ, 0, rd);
      check("freq read", {{24{env_level[7]}}, env_level}, rd);
    end
    $display("test receive data done");
    final_report();
  end
endmodule
`default_nettype wire
